/* File: rtl/sfr_bank.v */
// memory map, sample rom read path, sram pages and low sfrs of the core
`timescale 1ns/1ps
`include "sfr_bank_defs.vh"

////////////////////////////////////////////////////////////////////////////
// Behaviour
// - program rom is 12 bits; 0xf00-0xfff reserved, flagged, not blocked
// - entry 0x000 on reset, 0x004 on wake, 0x008 on interrupt
// - unused program words read 0xfff with fill option, else 0x000
// - sample rom returns bytes; 0x83c0-0x83ff system area, not blocked
// - 16-bit sample rom address from nibbles 18h (low) to 1bh (high)
// - sample rom data valid within two clocks after address write
// - 1ch reads low nibble, 1dh reads high nibble of addressed byte
// - write to 1dh restarts watchdog when watchdog option enabled
// - 00h-1fh always sfrs; 20h-3fh one of two sram pages
// - sram contents left uninitialised by reset
// - direct bit set/clear only on 00h-0fh
// - sfrs are operands of load, arithmetic, logic, rotate, compare
// - status: bit2 irq flag, bit1 carry, bit0 zero; bits 3:2 reset 0
// - port direction 02h, 1 output 0 input, resets 0000
// - 03h reads pin levels, writes output latch
// - 07h plain scratch nibble, undefined reset
// - 10-bit mode: 08h bits 3:2 give sample bits 1:0
// - 12-bit mode: 08h bits 3:0 give sample bits 3:0
// - 0ah gives bits 3:0, 5:2 or 7:4 by resolution
// - 0bh gives top four sample bits; bit 3 is sign, 0 positive
// - 09h bit0 output enable resets 0, bit1 global irq enable
module sfr_bank #(
  parameter PROGRAM_ROM_DEPTH = 4096,           // program words
  parameter SAMPLE_ROM_DEPTH = 33792           // sample rom bytes
) (
  input  wire        clk,                // 40 mhz system clock
  input  wire        rst_b,              // async reset, active low
  input  wire [5:0]  addr,               // direct data address
  input  wire        wr_en,              // write strobe, one cycle
  input  wire        rd_en,              // read strobe, one cycle
  input  wire [3:0]  wr_data,            // write nibble
  output reg  [3:0]  rd_data,            // read nibble, registered
  input  wire        bit_op,             // write is a bit set/clear
  input  wire [1:0]  bit_sel,            // bit index for bit op
  input  wire        bit_val,            // value for bit op
  output wire        bit_op_ok,          // bit op legal at addr
  input  wire        page_load,          // page load instruction
  input  wire        page_val,           // page value to load
  input  wire        flags_wr,           // alu updates carry and zero
  input  wire        carry_in,           // alu carry result
  input  wire        zero_in,            // alu zero result
  input  wire        audio_irq_set,      // audio irq event pulse
  input  wire        irq_ack,            // core clears audio flag
  input  wire        wake_req,           // wake request from halt
  input  wire        irq_req,            // interrupt taken
  output reg  [11:0] pc_entry,           // entry vector, registered
  output reg         pc_load,            // load entry vector pulse
  input  wire [11:0] prog_addr,          // program fetch address
  output reg  [11:0] prog_word,          // fetched program word
  output wire        prog_in_reserved,   // fetch in reserved area
  input  wire        unused_fill_option, // unused fill strap
  input  wire        wdt_option,         // watchdog enabled strap
  output reg         wdt_restart,        // watchdog restart pulse
  input  wire        ten_bit_option,     // 10-bit pwm option
  input  wire        twelve_bit_option,  // 12-bit pwm option
  output reg  [11:0] audio_sample,       // assembled pwm sample
  output wire        audio_out_enable,   // pwm stage enable
  output wire        global_irq_enable,  // global irq enable
  output wire        audio_irq_flag,     // pending audio irq
  output wire        sample_rom_in_system,     // address in system area
  input  wire [3:0]  port_pin_in,        // port a pin levels
  output wire [3:0]  port_pin_out,       // port a output latch
  output wire [3:0]  port_pin_oe         // port a drive enable
);

  ////////////////////////////////////////////////////////////////////////
  // storage
  reg [11:0] program_rom [0:PROGRAM_ROM_DEPTH-1];
  reg [7:0]  sample_rom  [0:SAMPLE_ROM_DEPTH-1];
  reg [3:0]  sram        [0:63];         // two pages of 32 nibbles
  reg        page_select_bit;
  reg [1:0]  status_hi_q;
  reg        carry_flag;
  reg        zero_flag;
  reg [3:0]  port_direction_reg;
  reg [3:0]  port_value_reg;
  reg [3:0]  scratch_nibble_one;
  reg [3:0]  sample_lowest_nibble;
  reg [3:0]  sample_low_nibble;
  reg [3:0]  sample_high_nibble;
  reg        out_en_q;
  reg        irq_en_q;
  reg [3:0]  rom_addr_q [0:3];
  reg [7:0]  rom_byte_q;
  reg [3:0]  pin_meta_q;
  reg [3:0]  pin_sync_q;
  reg [3:0]  wv;
  reg [3:0]  cur;
  integer    i;

  wire        is_sfr    = (addr <= `ADDR_SFR_TOP);
  wire [5:0]  sram_idx  = {page_select_bit, addr[4:0]};
  wire [15:0] rom_addr  = {rom_addr_q[3], rom_addr_q[2],
                           rom_addr_q[1], rom_addr_q[0]};

  assign bit_op_ok         = (addr <= `ADDR_BITOP_TOP);
  assign audio_out_enable  = out_en_q;
  assign global_irq_enable = irq_en_q;
  assign audio_irq_flag    = status_hi_q[0];
  assign port_pin_out      = port_value_reg;
  assign port_pin_oe       = port_direction_reg;
  // reserved areas are flagged only; no access is blocked
  assign prog_in_reserved  = (prog_addr >= `PC_RESERVED_LO);
  assign sample_rom_in_system    = (rom_addr >= `SAMPLE_ROM_SYS_FIRST) &&
                             (rom_addr <= `SAMPLE_ROM_SYS_LAST);

  ////////////////////////////////////////////////////////////////////////
  // current value of the addressed nibble, for bit ops and reads
  always @* begin
    cur = `RESERVED_READ;
    if (!is_sfr) begin
      cur = sram[sram_idx];
    end else begin
      case (addr)
        `ADDR_STATUS:     cur = {status_hi_q, carry_flag, zero_flag};
        `ADDR_PORT_DIR:   cur = port_direction_reg;
        `ADDR_PORT_VAL:   cur = pin_sync_q;
        `ADDR_SCRATCH1:   cur = scratch_nibble_one;
        `ADDR_AUDIO_CTRL: cur = {2'h0, irq_en_q, out_en_q};
        `ADDR_ROM_A0:     cur = rom_addr_q[0];
        `ADDR_ROM_A1:     cur = rom_addr_q[1];
        `ADDR_ROM_A2:     cur = rom_addr_q[2];
        `ADDR_ROM_A3:     cur = rom_addr_q[3];
        `ADDR_ROM_DL:     cur = rom_byte_q[3:0];
        `ADDR_ROM_DH:     cur = rom_byte_q[7:4];
        default:          cur = `RESERVED_READ;
      endcase
    end
  end

  // bit op merges one bit into the current nibble
  always @* begin
    wv = wr_data;
    if (bit_op) begin
      wv = cur;
      wv[bit_sel] = bit_val;
    end
  end

  wire do_wr = wr_en && (!bit_op || bit_op_ok);

  ////////////////////////////////////////////////////////////////////////
  // write decode, one strobe per target; one strobe shared by the four rom address nibbles
  wire wr_status = do_wr && (addr == `ADDR_STATUS);
  wire wr_dir    = do_wr && (addr == `ADDR_PORT_DIR);
  wire wr_pval   = do_wr && (addr == `ADDR_PORT_VAL);
  wire wr_scr    = do_wr && (addr == `ADDR_SCRATCH1);
  wire wr_lowest = do_wr && (addr == `ADDR_SMP_LOWEST);
  wire wr_ctrl   = do_wr && (addr == `ADDR_AUDIO_CTRL);
  wire wr_low    = do_wr && (addr == `ADDR_SMP_LOW);
  wire wr_high   = do_wr && (addr == `ADDR_SMP_HIGH);
  wire wr_rom_dh = do_wr && (addr == `ADDR_ROM_DH);
  wire wr_rom_a  = do_wr && (addr[5:2] == (`ADDR_ROM_A0 >> 2));
  wire wr_sram   = do_wr && !is_sfr;
  // writes to 1ch and to reserved addresses match nothing: ignored

  ////////////////////////////////////////////////////////////////////////
  // pin synchroniser, two flops per pin; only the second is read
  genvar n;
  generate
    for (n = 0; n < 4; n = n + 1) begin : g_pin_sync
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          pin_meta_q[n] <= 1'b0;
          pin_sync_q[n] <= 1'b0;
        end else begin
          pin_meta_q[n] <= port_pin_in[n];
          pin_sync_q[n] <= pin_meta_q[n];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // reset-defined control registers
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      port_direction_reg <= `RST_PORT_DIR;
    else if (wr_dir)
      port_direction_reg <= wv;
  end

  // enable bit 1 has no defined reset value; cleared to be safe
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_en_q <= `RST_OUT_EN;
      irq_en_q <= 1'b0;
    end else if (wr_ctrl) begin
      out_en_q <= wv[`CTRL_OUT_EN_BIT];
      irq_en_q <= wv[`CTRL_IRQ_EN_BIT];
    end
  end

  // one-cycle pulse; the watchdog counter lives outside this bank
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      wdt_restart <= 1'b0;
    else
      wdt_restart <= wr_rom_dh && wdt_option;
  end

  // bit 3 is reserved and keeps its reset value
  // hardware set wins over a clear in the same cycle
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      status_hi_q <= `RST_STATUS_HI;
    else if (audio_irq_set)
      status_hi_q[0] <= 1'b1;
    else if (irq_ack)
      status_hi_q[0] <= 1'b0;
    else if (wr_status)
      status_hi_q[0] <= wv[`STATUS_IRQ_BIT];
  end

  ////////////////////////////////////////////////////////////////////////
  // registers with undefined reset value; sram never reset
  // alu result wins over a direct write of the status nibble
  always @(posedge clk) begin
    if (flags_wr) begin
      carry_flag <= carry_in;
      zero_flag  <= zero_in;
    end else if (wr_status) begin
      carry_flag <= wv[`STATUS_CARRY_BIT];
      zero_flag  <= wv[`STATUS_ZERO_BIT];
    end
  end

  // no reset: software must load the page bit first
  always @(posedge clk) begin
    if (page_load)
      page_select_bit <= page_val;
  end

  always @(posedge clk) begin
    if (wr_sram)
      sram[sram_idx] <= wv;
  end

  always @(posedge clk) begin
    if (wr_pval)
      port_value_reg <= wv;
    if (wr_scr)
      scratch_nibble_one <= wv;
  end

  // sample nibbles are write-only; they read back as reserved
  always @(posedge clk) begin
    if (wr_lowest)
      sample_lowest_nibble <= wv;
    if (wr_low)
      sample_low_nibble <= wv;
    if (wr_high)
      sample_high_nibble <= wv;
  end

  ////////////////////////////////////////////////////////////////////////
  // sample rom address nibbles and data latch
  generate
    for (n = 0; n < 4; n = n + 1) begin : g_rom_addr
      always @(posedge clk) begin
        if (wr_rom_a && addr[1:0] == n)
          rom_addr_q[n] <= wv;
      end
    end
  endgenerate

  // latch follows the address every cycle: ready one cycle after a
  // nibble write, inside the two-cycle limit
  always @(posedge clk) begin
    rom_byte_q <= sample_rom[rom_addr];
  end

  ////////////////////////////////////////////////////////////////////////
  // read port
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      rd_data <= 4'h0;
    else if (rd_en)
      rd_data <= cur;
  end

  ////////////////////////////////////////////////////////////////////////
  // program fetch; the image holds no code, so every word is unused
  // and the live fill strap decides what a fetch returns
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      prog_word <= `FILL_CLEAR;
    else
      prog_word <= program_rom[prog_addr] |
                   {12{unused_fill_option}};
  end

  // entry vectors; wake takes priority over an interrupt
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_entry <= `PC_RESET;
      pc_load  <= 1'b1;
    end else begin
      pc_load <= wake_req | irq_req;
      if (wake_req)
        pc_entry <= `PC_WAKEUP;
      else if (irq_req)
        pc_entry <= `PC_IRQ;
    end
  end

  // empty images at elaboration
  initial begin
    for (i = 0; i < PROGRAM_ROM_DEPTH; i = i + 1)
      program_rom[i] = `FILL_CLEAR;
    for (i = 0; i < SAMPLE_ROM_DEPTH; i = i + 1)
      sample_rom[i] = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  // sample assembly by resolution; twelve-bit option wins
  localparam [1:0] RES_8  = 2'h0;
  localparam [1:0] RES_10 = 2'h1;
  localparam [1:0] RES_12 = 2'h2;

  wire [1:0] res_mode = twelve_bit_option ? RES_12 :
                        ten_bit_option    ? RES_10 : RES_8;

  always @* begin
    case (res_mode)
      RES_12:
        audio_sample = {sample_high_nibble, sample_low_nibble,
                        sample_lowest_nibble};
      RES_10:
        audio_sample = {2'h0, sample_high_nibble, sample_low_nibble,
                        sample_lowest_nibble[3:2]};
      default:
        audio_sample = {4'h0, sample_high_nibble,
                        sample_low_nibble};
    endcase
  end

endmodule // sfr_bank

/* File: rtl/sfr_bank_defs.vh */
// register offsets, reset values and timing counts for the sfr bank
`ifndef SFR_BANK_DEFS_VH
`define SFR_BANK_DEFS_VH
`define ADDR_STATUS      6'h00
`define ADDR_PORT_DIR    6'h02
`define ADDR_PORT_VAL    6'h03
`define ADDR_SCRATCH1    6'h07
`define ADDR_SMP_LOWEST  6'h08
`define ADDR_AUDIO_CTRL  6'h09
`define ADDR_SMP_LOW     6'h0a
`define ADDR_SMP_HIGH    6'h0b
`define ADDR_ROM_A0      6'h18
`define ADDR_ROM_A1      6'h19
`define ADDR_ROM_A2      6'h1a
`define ADDR_ROM_A3      6'h1b
`define ADDR_ROM_DL      6'h1c
`define ADDR_ROM_DH      6'h1d
`define ADDR_BITOP_TOP   6'h0f
`define ADDR_SFR_TOP     6'h1f
`define STATUS_IRQ_BIT   2
`define STATUS_CARRY_BIT 1
`define STATUS_ZERO_BIT  0
`define CTRL_OUT_EN_BIT  0
`define CTRL_IRQ_EN_BIT  1
`define RST_PORT_DIR     4'h0
`define RST_STATUS_HI    2'h0
`define RST_OUT_EN       1'b0
`define RESERVED_READ    4'h0
`define PC_RESET         12'h000
`define PC_WAKEUP        12'h004
`define PC_IRQ           12'h008
`define PC_USER_FIRST    12'h00a
`define PC_RESERVED_LO   12'hf00
`define FILL_SET         12'hfff
`define FILL_CLEAR       12'h000
`define SAMPLE_ROM_SYS_FIRST   16'h83c0
`define SAMPLE_ROM_SYS_LAST    16'h83ff
`define SAMPLE_ROM_READY_CYC   2
`endif

/* File: bench/sfr_bank_props.sv */
// assertion checker for the sfr bank ports
`timescale 1ns/1ps
module sfr_bank_props (
  input wire        clk,              // clock
  input wire        rst_b,            // reset
  input wire [5:0]  addr,             // address
  input wire        wr_en,            // write
  input wire [3:0]  wr_data,          // data
  input wire        bit_op,           // bit op
  input wire        bit_op_ok,        // bit legal
  input wire [11:0] prog_addr,        // fetch
  input wire        prog_in_reserved, // reserved
  input wire        wake_req,         // wake
  input wire        irq_req,          // irq
  input wire [11:0] pc_entry,         // vector
  input wire        pc_load,          // load
  input wire        wdt_option,       // wdt on
  input wire        wdt_restart,      // restart
  input wire        audio_irq_set,    // set
  input wire        audio_irq_flag,   // flag
  input wire [3:0]  port_pin_oe,      // oe
  input wire        audio_out_enable, // out en
  input wire        global_irq_enable // irq en
);
  wire plain_wr = wr_en && !bit_op;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////
  bit_legal_a: assert property (bit_op_ok == (addr <= 6'h0f))
    else $error("bit op legality wrong");
  prog_resv_a: assert property (prog_in_reserved == (prog_addr >= 12'hf00))
    else $error("reserved fetch flag wrong");
  wake_vec_a: assert property (wake_req |=> pc_load && pc_entry == 12'h004)
    else $error("wake vector wrong");
  irq_vec_a: assert property (irq_req && !wake_req |=> pc_load && pc_entry == 12'h008)
    else $error("irq vector wrong");
  wdt_kick_a: assert property (wdt_restart == $past(plain_wr && addr == 6'h1d && wdt_option))
    else $error("watchdog restart wrong");
  irq_flag_a: assert property (audio_irq_set |=> audio_irq_flag)
    else $error("audio flag not set");
  dir_write_a: assert property (plain_wr && addr == 6'h02 |=> port_pin_oe == $past(wr_data))
    else $error("direction write lost");
  ctrl_write_a: assert property (plain_wr && addr == 6'h09 |=>
    {global_irq_enable, audio_out_enable} == $past(wr_data[1:0]))
    else $error("control write lost");
  cover property (wake_req && irq_req);
  cover property (audio_irq_set ##1 audio_irq_flag);
  cover property (plain_wr && addr == 6'h1d && wdt_option);
endmodule // sfr_bank_props

/* File: bench/core_model.sv */
// processor core model issuing sfr and sram accesses
`timescale 1ns/1ps
module core_model (
  input  wire       clk,       // clock
  input  wire [3:0] rd_data,   // read nibble
  output reg  [5:0] addr,      // address
  output reg        wr_en,     // write
  output reg        rd_en,     // read
  output reg  [3:0] wr_data,   // data
  output reg        bit_op,    // bit op
  output reg  [1:0] bit_sel,   // bit index
  output reg        bit_val,   // bit value
  output reg        page_load, // page load
  output reg        page_val   // page value
);
  initial {addr, wr_en, rd_en, wr_data, bit_op, bit_sel, bit_val} = 0;
  initial {page_load, page_val} = 0;
  ////////////////////////////////////////////////////////////////////////////
  // strobe one cycle, then a gap: the gap covers the rom ready delay
  task acc(input w, r, b, input [5:0] a, input [3:0] d, output [3:0] q);
    @(negedge clk);
    {wr_en, rd_en, bit_op, addr, wr_data} = {w, r, b, a, d};
    {bit_sel, bit_val} = d[2:0];
    @(negedge clk);
    {wr_en, rd_en, bit_op} = 3'h0;
    wr_data = ~wr_data;
    @(negedge clk);
    q = rd_data;
  endtask
  task pload(input v);
    @(negedge clk);
    {page_load, page_val} = {1'b1, v};
    @(negedge clk);
    {page_load, page_val} = {1'b0, ~v};
  endtask
endmodule // core_model

/* File: bench/test_sfr_bank.sv */
// self-checking bench for the sfr bank
`timescale 1ns/1ps
`define CHK(g, x) begin n_tests++; if ((g) !== (x)) begin err_total++; \
  $display("FAIL %0t got %h exp %h", $time, g, x); end end
module test_sfr_bank;
  reg         clk, rst_b, flags_wr, carry_in, zero_in, audio_irq_set;
  reg         irq_ack, wake_req, irq_req, unused_fill_option, wdt_option;
  reg         ten_bit_option, twelve_bit_option;
  reg  [11:0] prog_addr, e;
  reg  [3:0]  port_pin_in, q;
  reg  [31:0] t, seed;
  integer     err_total, n_tests, i, k, m;
  wire [5:0]  addr;
  wire [1:0]  bit_sel;
  wire [3:0]  wr_data, rd_data, port_pin_out, port_pin_oe;
  wire [11:0] pc_entry, prog_word, audio_sample;
  wire        wr_en, rd_en, bit_op, bit_val, page_load, page_val, bit_op_ok;
  wire        pc_load, prog_in_reserved, wdt_restart, audio_out_enable;
  wire        global_irq_enable, audio_irq_flag, sample_rom_in_system;
  sfr_bank dut (.*);
  core_model core (.*);
  function [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    rnd = seed;
  endfunction
  function [11:0] smp(input integer md, input [3:0] lw, lo, hi);
    smp = md == 0 ? {4'h0, hi, lo} : md == 1 ? {2'h0, hi, lo, lw[3:2]}
        : {hi, lo, lw};
  endfunction
  task wr(input [5:0] a, input [3:0] d);
    core.acc(1, 0, 0, a, d, q);
  endtask
  task rd(input [5:0] a, input [3:0] x);
    core.acc(0, 1, 0, a, 4'h0, q);
    `CHK(q, x)
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #(25 * 20000);
    err_total++;
    wrap_up;
  end
  initial begin
    {flags_wr, carry_in, zero_in, audio_irq_set, irq_ack, wake_req} = 0;
    {irq_req, unused_fill_option, wdt_option} = 0;
    {ten_bit_option, twelve_bit_option, prog_addr, port_pin_in} = 0;
    {err_total, n_tests, rst_b, seed} = {64'h0, 1'b0, 32'hd6b5f738};
    repeat (10) @(negedge clk);
    `CHK(pc_entry, 12'h000)
    rst_b = 1;
    rd(6'h02, 4'h0);
    `CHK({audio_out_enable, audio_irq_flag}, 2'b00)
    for (i = 0; i < 16; i++) begin
      t = rnd();
      // corners on both sides of the system area edge
      if (i < 2) t[15:0] = i ? 16'h83bf : 16'h83c0;
      wdt_option = t[16];
      core.pload(0);
      wr({1'b1, t[4:0]}, t[11:8]);
      core.pload(1);
      wr({1'b1, t[4:0]}, t[15:12]);
      rd({1'b1, t[4:0]}, t[15:12]);
      core.pload(0);
      rd({1'b1, t[4:0]}, t[11:8]);
      wr(6'h07, t[19:16]);
      rd(6'h07, t[19:16]);
      core.acc(1, 0, 1, 6'h07, {1'b0, t[21:20], 1'b1}, q);
      rd(6'h07, t[19:16] | (4'h1 << t[21:20]));
      wr(6'h01, t[3:0]);
      rd(6'h01, 4'h0);
      wr(6'h02, t[23:20]);
      wr(6'h03, t[27:24]);
      `CHK({port_pin_out, port_pin_oe}, t[27:20])
      port_pin_in = t[31:28];
      repeat (3) @(negedge clk);
      rd(6'h03, t[31:28]);
      wr(6'h09, t[7:4]);
      `CHK({global_irq_enable, audio_out_enable}, t[5:4])
      m = i % 3;
      twelve_bit_option = m == 2;
      ten_bit_option = m == 1 || (m == 2 && t[0]);
      wr(6'h08, t[3:0]);
      wr(6'h0a, t[7:4]);
      wr(6'h0b, t[11:8]);
      e = smp(m, t[3:0], t[7:4], t[11:8]);
      `CHK(audio_sample & (12'hfff >> (4 - 2 * m)), e)
      for (k = 0; k < 4; k++) wr(6'h18 + k[5:0], t[4 * k +: 4]);
      `CHK(sample_rom_in_system, t[15:6] == 10'h20f)
      core.acc(1, 0, 1, 6'h1b, 4'h1, q);
      `CHK(sample_rom_in_system, t[15:6] == 10'h20f)
      rd(6'h1c, 4'h0);
      rd(6'h1d, 4'h0);
      wr(6'h1d, t[3:0]);
    end
    for (i = 0; i < 3; i++) begin
      @(negedge clk);
      {wake_req, irq_req} = 2'(i + 1);
      @(negedge clk);
      {wake_req, irq_req} = 2'b00;
      `CHK(pc_entry, i == 0 ? 12'h008 : 12'h004)
    end
    for (i = 0; i < 2; i++) begin
      @(negedge clk);
      {audio_irq_set, irq_ack} = i ? 2'b01 : 2'b10;
      @(negedge clk);
      {audio_irq_set, irq_ack} = 2'b00;
      core.acc(0, 1, 0, 6'h00, 4'h0, q);
      `CHK(q[3:2], i ? 2'b00 : 2'b01)
    end
    for (i = 0; i < 4; i++) begin
      t = rnd();
      unused_fill_option = i[0];
      prog_addr = i[1] ? 12'hf00 : t[11:0];
      repeat (2) @(negedge clk);
      `CHK(prog_word, i[0] ? 12'hfff : 12'h000)
    end
    wrap_up;
  end
endmodule // test_sfr_bank
bind sfr_bank sfr_bank_props chk (.*);
